// ### rtl/i2c_transfer_status_flags.sv
// Status flag logic of an I2C/SMBus controller, Avalon-MM register slave.
// Assumes the controller datapath drives the event inputs on ref_clk_i
// and that the bus pins scl_i and sda_i are asynchronous.
//
// Operation
// - Receive full set on move, cleared on read
// - Data read keeps full when byte pending
// - Stop seen in slave; status then control
// - Header sent in master; status then data
// - Byte finished while stretching and stalled
// - Byte finished cleared: sequence, start/stop, disable
// - Address flag set; cleared reading both statuses
// - Start sent flag; status then data write
// - Check value shown while checking enabled
// - Dual match shows which own address
// - Address kind flags cleared start/stop/disable
// - Host header flag in slave mode
// - Default address flag on reception
// - General call flag on address zero
// - Direction flag, cleared start/stop/disable/arbitration
// - Bus active cleared after stop
// - Master set on start, cleared on stop, disable or arbitration loss
// - Second status read-only, reserved bits zero
// - Arbitration loss sets flag, back to slave
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/10ps
`include "i2c_flag_consts.svh"
module i2c_transfer_status_flags
   import i2c_flag_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rstn_i,
   // Avalon-MM slave
   input  wire logic [7:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   output logic [31:0]      readdata_o,
   output logic             waitrequest_o,
   // Bus pins
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   // Datapath events, master side
   input  wire logic        start_gen_i,
   input  wire logic        stop_gen_i,
   input  wire logic        header10_sent_i,
   input  wire logic        addr_acked_i,
   input  wire logic        arb_lost_i,
   // Datapath events, slave side
   input  wire logic        addr_match_i,
   input  wire logic        addr_match_second_i,
   input  wire logic        gen_call_i,
   input  wire logic        smb_host_i,
   input  wire logic        smb_default_i,
   // Direction
   input  wire logic        dir_valid_i,
   input  wire logic        dir_send_i,
   // Byte movement
   input  wire logic        rx_byte_done_i,
   input  wire logic [7:0]  rx_byte_i,
   input  wire logic        tx_byte_done_i,
   input  wire logic        tx_hold_empty_i,
   input  wire logic [7:0]  pec_value_i,
   // Status outputs
   output logic             peripheral_on_o,
   output logic             pec_enable_o,
   output logic             scl_hold_o,
   output logic             master_mode_o,
   output logic             bus_active_o
);

   flag_state_t s_r;
   flag_state_t s_nxt;
   logic        scl_s;
   logic        sda_s;

   // Pin synchronisers
   sync2 u_sync_scl (
      .ref_clk_i (ref_clk_i),
      .rstn_i    (rstn_i),
      .d_i       (scl_i),
      .q_o       (scl_s)
   );

   sync2 u_sync_sda (
      .ref_clk_i (ref_clk_i),
      .rstn_i    (rstn_i),
      .d_i       (sda_i),
      .q_o       (sda_s)
   );

   logic        req;
   logic        acc;
   logic        acc_rd;
   logic        acc_wr;
   logic        on;
   logic        stretch_on;
   logic        pec_on;
   logic        bus_start;
   logic        bus_stop;
   logic        any_start_stop;
   logic        gen_start_stop;
   logic [31:0] rd_val;
   logic [31:0] stat0;
   logic [31:0] stat1;

   assign req        = read_i | write_i;
   assign acc        = req & s_r.ack;
   assign acc_rd     = acc & read_i;
   assign acc_wr     = acc & write_i;
   assign on         = s_r.ctl[`CTL_ON_BIT];
   assign pec_on     = s_r.ctl[`CTL_PEC_EN_BIT];
   assign stretch_on = ~s_r.ctl[`CTL_STRETCH_OFF_BIT];

   // Start and stop on the bus
   assign bus_start      = s_r.scl_d & scl_s & s_r.sda_d & ~sda_s;
   assign bus_stop       = s_r.scl_d & scl_s & ~s_r.sda_d & sda_s;
   assign any_start_stop = bus_start | bus_stop | start_gen_i | stop_gen_i;
   assign gen_start_stop = start_gen_i | stop_gen_i;

   // Status images
   always_comb begin
      stat0 = `WORD_RESET;
      stat0[`S0_ARB_LOST]  = s_r.arbitration_lost_flag;
      stat0[`S0_RX_FULL]   = s_r.rx_holding_full_flag;
      stat0[`S0_STOP_SEEN] = s_r.stop_seen_flag;
      stat0[`S0_HDR10_OUT] = s_r.ten_bit_header_out_flag;
      stat0[`S0_BYTE_FIN]  = s_r.byte_finished_flag;
      stat0[`S0_ADDR_DONE] = s_r.address_phase_done_flag;
      stat0[`S0_START_OUT] = s_r.start_out_flag;
   end

   always_comb begin
      stat1 = `S1_RESET;
      if (pec_on) begin
         stat1[`S1_CHECK_MSB:`S1_CHECK_LSB] = pec_value_i;
      end
      stat1[`S1_DUAL_MATCH]   = s_r.dual_match_indicator;
      stat1[`S1_HOST_HDR]     = s_r.smbus_host_header_flag;
      stat1[`S1_DEFAULT_ADDR] = s_r.smbus_default_addr_flag;
      stat1[`S1_GEN_CALL]     = s_r.general_call_seen_flag;
      stat1[`S1_DIR_SEND]     = s_r.direction_is_send_flag;
      stat1[`S1_BUS_ACTIVE]   = s_r.bus_active_flag;
      stat1[`S1_MASTER]       = s_r.master_flag;
   end

   // Read mux, unmapped reads as zero
   always_comb begin
      unique case (address_i)
         `OFS_CONTROL_FIRST: rd_val = {16'h0000, s_r.ctl};
         `OFS_DATA_HOLD:     rd_val = {24'h00_0000, s_r.rx_hold};
         `OFS_STATUS_FIRST:  rd_val = stat0;
         `OFS_STATUS_SECOND: rd_val = stat1;
         default:            rd_val = `WORD_RESET;
      endcase
   end

   // Next state
   always_comb begin
      logic rd_data;
      logic wr_data;
      logic wr_ctl;
      logic rd_s0;
      logic rd_s1;
      logic wr_s0;
      logic seq;
      rd_data = acc_rd & (address_i == `OFS_DATA_HOLD);
      wr_data = acc_wr & (address_i == `OFS_DATA_HOLD);
      wr_ctl  = acc_wr & (address_i == `OFS_CONTROL_FIRST);
      rd_s0   = acc_rd & (address_i == `OFS_STATUS_FIRST);
      rd_s1   = acc_rd & (address_i == `OFS_STATUS_SECOND);
      wr_s0   = acc_wr & (address_i == `OFS_STATUS_FIRST);
      seq     = s_r.stat0_rd;
      s_nxt   = s_r;

      // Bus slave: one wait cycle, data stands at the accept edge
      s_nxt.ack = req & ~s_r.ack;
      if (req & ~s_r.ack) begin
         s_nxt.rdata = rd_val;
      end
      if (acc) begin
         s_nxt.stat0_rd = rd_s0;
      end
      if (wr_ctl) begin
         s_nxt.ctl = writedata_i[15:0] & `CTL_WRITE_MASK;
      end

      s_nxt.scl_d = scl_s;
      s_nxt.sda_d = sda_s;

      // Clears first, sets after so that sets win
      if (rd_data) begin
         if (s_r.byte_finished_flag & s_r.rx_holding_full_flag) begin
            s_nxt.rx_hold = s_r.rx_pend;
         end else begin
            s_nxt.rx_holding_full_flag = 1'b0;
         end
      end
      if (seq & wr_ctl) begin
         s_nxt.stop_seen_flag = 1'b0;
      end
      if (seq & wr_data) begin
         s_nxt.ten_bit_header_out_flag = 1'b0;
         s_nxt.start_out_flag          = 1'b0;
      end
      if ((seq & (rd_data | wr_data)) | gen_start_stop | ~on) begin
         s_nxt.byte_finished_flag = 1'b0;
      end
      if (seq & rd_s1) begin
         s_nxt.address_phase_done_flag = 1'b0;
      end
      if (wr_s0 & ~writedata_i[`S0_ARB_LOST]) begin
         s_nxt.arbitration_lost_flag = 1'b0;
      end
      if (any_start_stop | ~on) begin
         s_nxt.dual_match_indicator    = 1'b0;
         s_nxt.smbus_host_header_flag  = 1'b0;
         s_nxt.smbus_default_addr_flag = 1'b0;
         s_nxt.general_call_seen_flag  = 1'b0;
      end
      if (any_start_stop | ~on | arb_lost_i) begin
         s_nxt.direction_is_send_flag = 1'b0;
      end
      if (bus_stop) begin
         s_nxt.bus_active_flag = 1'b0;
      end
      if (bus_stop | stop_gen_i | ~on | arb_lost_i) begin
         s_nxt.master_flag = 1'b0;
      end

      // Receive path into the holding register, and byte finished on transmit
      if (rx_byte_done_i) begin
         if (!s_nxt.rx_holding_full_flag) begin
            s_nxt.rx_hold              = rx_byte_i;
            s_nxt.rx_holding_full_flag = 1'b1;
         end else if (stretch_on) begin
            s_nxt.rx_pend            = rx_byte_i;
            s_nxt.byte_finished_flag = 1'b1;
         end
      end
      if (tx_byte_done_i & tx_hold_empty_i & stretch_on) begin
         s_nxt.byte_finished_flag = 1'b1;
      end

      // Bus and mode events
      if (on) begin
         if (bus_stop & ~s_r.master_flag) begin
            s_nxt.stop_seen_flag = 1'b1;
         end
         if (header10_sent_i & s_r.master_flag) begin
            s_nxt.ten_bit_header_out_flag = 1'b1;
         end
         if ((addr_acked_i & s_r.master_flag) |
             (addr_match_i & ~s_r.master_flag)) begin
            s_nxt.address_phase_done_flag = 1'b1;
         end
         if (addr_match_i & ~s_r.master_flag) begin
            s_nxt.dual_match_indicator = addr_match_second_i;
         end
         if (smb_host_i & ~s_r.master_flag) begin
            s_nxt.smbus_host_header_flag = 1'b1;
         end
         if (smb_default_i) begin
            s_nxt.smbus_default_addr_flag = 1'b1;
         end
         if (gen_call_i) begin
            s_nxt.general_call_seen_flag = 1'b1;
         end
         if (dir_valid_i) begin
            s_nxt.direction_is_send_flag = dir_send_i;
         end
         if (start_gen_i) begin
            s_nxt.start_out_flag = 1'b1;
            s_nxt.master_flag    = 1'b1;
         end
         if (arb_lost_i) begin
            s_nxt.arbitration_lost_flag = 1'b1;
         end
      end
      if (bus_start) begin
         s_nxt.bus_active_flag = 1'b1;
      end
   end

   // State register
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r.ack                     <= 1'b0;
         s_r.rdata                   <= `WORD_RESET;
         s_r.scl_d                   <= 1'b1;
         s_r.sda_d                   <= 1'b1;
         s_r.stat0_rd                <= 1'b0;
         s_r.ctl                     <= `CTL_RESET;
         s_r.rx_hold                 <= `BYTE_RESET;
         s_r.rx_pend                 <= `BYTE_RESET;
         s_r.rx_holding_full_flag    <= 1'b0;
         s_r.byte_finished_flag      <= 1'b0;
         s_r.stop_seen_flag          <= 1'b0;
         s_r.ten_bit_header_out_flag <= 1'b0;
         s_r.address_phase_done_flag <= 1'b0;
         s_r.start_out_flag          <= 1'b0;
         s_r.arbitration_lost_flag   <= 1'b0;
         s_r.dual_match_indicator    <= 1'b0;
         s_r.smbus_host_header_flag  <= 1'b0;
         s_r.smbus_default_addr_flag <= 1'b0;
         s_r.general_call_seen_flag  <= 1'b0;
         s_r.direction_is_send_flag  <= 1'b0;
         s_r.bus_active_flag         <= 1'b0;
         s_r.master_flag             <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs
   assign waitrequest_o   = req & ~s_r.ack;
   assign readdata_o      = s_r.rdata;
   assign peripheral_on_o = on;
   assign pec_enable_o    = pec_on;
   assign scl_hold_o      = s_r.byte_finished_flag;
   assign master_mode_o   = s_r.master_flag;
   assign bus_active_o    = s_r.bus_active_flag;

endmodule : i2c_transfer_status_flags

// ### rtl/i2c_flag_consts.svh
// Constants for the transfer status flag block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef I2C_FLAG_CONSTS_SVH
`define I2C_FLAG_CONSTS_SVH

// Register byte offsets
`define OFS_CONTROL_FIRST   8'h00
`define OFS_DATA_HOLD       8'h10
`define OFS_STATUS_FIRST    8'h14
`define OFS_STATUS_SECOND   8'h18

// Control register fields
`define CTL_ON_BIT          0
`define CTL_PEC_EN_BIT      1
`define CTL_STRETCH_OFF_BIT 7
`define CTL_WRITE_MASK      16'h0083
`define CTL_RESET           16'h0000

// First status register fields
`define S0_ARB_LOST         9
`define S0_RX_FULL          6
`define S0_STOP_SEEN        4
`define S0_HDR10_OUT        3
`define S0_BYTE_FIN         2
`define S0_ADDR_DONE        1
`define S0_START_OUT        0

// Second status register fields
`define S1_CHECK_LSB        8
`define S1_CHECK_MSB        15
`define S1_DUAL_MATCH       7
`define S1_HOST_HDR         6
`define S1_DEFAULT_ADDR     5
`define S1_GEN_CALL         4
`define S1_DIR_SEND         2
`define S1_BUS_ACTIVE       1
`define S1_MASTER           0
`define S1_RESET            32'h0000_0000

`define BYTE_RESET          8'h00
`define WORD_RESET          32'h0000_0000

`endif

// ### rtl/i2c_flag_pkg.sv
// Types for the transfer status flag block.
// Assumes nothing beyond a SystemVerilog compiler.
package i2c_flag_pkg;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
      logic        scl_d;
      logic        sda_d;
      logic        stat0_rd;
      logic [15:0] ctl;
      logic [7:0]  rx_hold;
      logic [7:0]  rx_pend;
      logic        rx_holding_full_flag;
      logic        byte_finished_flag;
      logic        stop_seen_flag;
      logic        ten_bit_header_out_flag;
      logic        address_phase_done_flag;
      logic        start_out_flag;
      logic        arbitration_lost_flag;
      logic        dual_match_indicator;
      logic        smbus_host_header_flag;
      logic        smbus_default_addr_flag;
      logic        general_call_seen_flag;
      logic        direction_is_send_flag;
      logic        bus_active_flag;
      logic        master_flag;
   } flag_state_t;

endpackage : i2c_flag_pkg

// ### rtl/sync2.sv
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the input may change at any time.
`timescale 1ns/10ps
module sync2 (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rstn_i,
   // Level in and out
   input  wire logic d_i,
   output logic      q_o
);
   logic meta_r;

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_r <= 1'b1;
         q_o    <= 1'b1;
      end else begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule : sync2

// ### bench/i2c_flag_checker.sv
// Port assertions for the transfer status flag block.
// Assumes a bind to the top module and a master that holds requests.
`timescale 1ns/10ps
`include "i2c_flag_consts.svh"
module i2c_flag_checker (
   // Clock and reset
   input wire logic        ref_clk_i,
   input wire logic        rstn_i,
   // Register bus
   input wire logic [7:0]  address_i,
   input wire logic        read_i,
   input wire logic        write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [31:0] readdata_o,
   input wire logic        waitrequest_o,
   // Pins and events
   input wire logic        scl_i,
   input wire logic        sda_i,
   input wire logic        start_gen_i,
   input wire logic        stop_gen_i,
   input wire logic        arb_lost_i,
   input wire logic        rx_byte_done_i,
   input wire logic        tx_byte_done_i,
   input wire logic [7:0]  pec_value_i,
   // Flags
   input wire logic        peripheral_on_o,
   input wire logic        pec_enable_o,
   input wire logic        scl_hold_o,
   input wire logic        master_mode_o,
   input wire logic        bus_active_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   logic req;
   logic rd2;
   assign req = read_i | write_i;
   assign rd2 = read_i && waitrequest_o && address_i == `OFS_STATUS_SECOND;
   wait_one_a:
      assert property (waitrequest_o |=> !waitrequest_o)
      else $error("wait too long");
   first_wait_a:
      assert property ($rose(req) |-> waitrequest_o)
      else $error("no wait cycle");
   ctl_write_a:
      assert property (write_i && !waitrequest_o &&
         address_i == `OFS_CONTROL_FIRST |=>
         {pec_enable_o, peripheral_on_o} == $past(writedata_i[1:0]))
      else $error("control not written");
   second_rsvd_a:
      assert property (rd2 |=> readdata_o[31:16] == 16'h0000 &&
         !readdata_o[3])
      else $error("reserved bit set");
   check_value_a:
      assert property (rd2 && pec_enable_o |=>
         readdata_o[15:8] == $past(pec_value_i))
      else $error("check value wrong");
   master_set_a:
      assert property (start_gen_i && peripheral_on_o |=> master_mode_o)
      else $error("master not set");
   master_clear_a:
      assert property ((stop_gen_i || arb_lost_i || !peripheral_on_o) &&
         !start_gen_i |=> !master_mode_o)
      else $error("master not cleared");
   hold_clear_a:
      assert property ((start_gen_i || stop_gen_i || !peripheral_on_o) &&
         !rx_byte_done_i && !tx_byte_done_i |=> !scl_hold_o)
      else $error("byte flag not cleared");
   busy_set_a:
      assert property (scl_i && $fell(sda_i) |-> ##[1:6] bus_active_o)
      else $error("busy not set");
   busy_clear_a:
      assert property (scl_i && $rose(sda_i) && !start_gen_i |->
         ##[1:6] !bus_active_o)
      else $error("busy not cleared");
   cover property (start_gen_i && peripheral_on_o);
   cover property (scl_i && $fell(sda_i));
   cover property (scl_hold_o && rx_byte_done_i);
endmodule : i2c_flag_checker

// ### bench/i2c_bus_model.sv
// Another device on the bus: makes START, clocks and STOP.
// Assumes pull-ups, so a released line reads high.
`timescale 1ns/10ps
module i2c_bus_model (
   // Bus lines
   output logic scl_o,
   output logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic bus_start;
      #50 sda_o = 1'b0;
      #50 scl_o = 1'b0;
   endtask : bus_start
   task automatic clocks(input int n);
      repeat (n) begin
         #50 sda_o = 1'($urandom);
         #50 scl_o = 1'b1;
         #100 scl_o = 1'b0;
      end
   endtask : clocks
   task automatic bus_stop;
      #50 sda_o = 1'b0;
      #50 scl_o = 1'b1;
      #50 sda_o = 1'b1;
   endtask : bus_stop
endmodule : i2c_bus_model

// ### bench/tb_top.sv
// Bench for the status flag block with random events and bytes.
// Assumes the bus model stands for the far side of the pins.
`timescale 1ns/10ps
`include "i2c_flag_consts.svh"
module tb_top;
   logic        clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0;
   logic        empty = 1'b0, scnd = 1'b0, dsend = 1'b0;
   logic [7:0]  adr = 8'h00, rxb = 8'h00, pec = 8'h00, b1, b2;
   logic [11:0] ev = 12'h000, m;
   logic [31:0] wd = 32'h0000_0000, rdat, rdo;
   logic        wt, on, pen, hold, mst, bsy, scl, sda;
   int          n_fail = 0, checks = 0;
   always #12.5 clk = ~clk;
   i2c_bus_model pm (.scl_o(scl), .sda_o(sda));
   i2c_transfer_status_flags uut (
      .ref_clk_i(clk), .rstn_i(rstn), .address_i(adr), .read_i(rd),
      .write_i(wr), .writedata_i(wd), .readdata_o(rdo),
      .waitrequest_o(wt), .scl_i(scl), .sda_i(sda),
      .start_gen_i(ev[0]), .stop_gen_i(ev[1]), .header10_sent_i(ev[2]),
      .addr_acked_i(ev[3]), .arb_lost_i(ev[4]), .addr_match_i(ev[5]),
      .addr_match_second_i(scnd), .gen_call_i(ev[6]),
      .smb_host_i(ev[7]), .smb_default_i(ev[8]), .dir_valid_i(ev[9]),
      .dir_send_i(dsend), .rx_byte_done_i(ev[10]), .rx_byte_i(rxb),
      .tx_byte_done_i(ev[11]), .tx_hold_empty_i(empty),
      .pec_value_i(pec), .peripheral_on_o(on), .pec_enable_o(pen),
      .scl_hold_o(hold), .master_mode_o(mst), .bus_active_o(bsy));
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      adr <= a;
      rd <= ~w;
      wr <= w;
      wd <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wt !== 1'b0 && n < 20);
      if (n >= 20)
         n_fail++;
      rdat = rdo;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : xfer
   task automatic rr(input logic [7:0] a);
      xfer(a, 1'b0, 32'h0000_0000);
   endtask : rr
   task automatic ww(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask : ww
   task automatic pulse(input logic [11:0] e, input logic [7:0] b = 8'h00);
      @(posedge clk);
      ev <= e;
      rxb <= b;
      @(posedge clk);
      ev <= 12'h000;
      @(negedge clk);
   endtask : pulse
   task automatic chk_reg(input logic [31:0] e, input logic [31:0] k);
      checks++;
      if ((rdat & k) !== (e & k)) begin
         n_fail++;
         $display("wrong value at %0t: %h vs %h", $time, rdat & k, e & k);
      end
   endtask : chk_reg
   task automatic chk_pin(input logic e, input logic g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: %h vs %h", $time, g, e);
      end
   endtask : chk_pin
   task automatic print_verdict;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   initial begin
      #100000;
      n_fail++;
      print_verdict();
   end
   initial begin
      void'($urandom(73903));
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      ww(`OFS_STATUS_SECOND, 32'hFFFF_FFFF);
      rr(`OFS_STATUS_SECOND);
      chk_reg(32'h0000_0000, 32'hFFFF_FFFF);
      rr(8'h40);
      chk_reg(32'h0000_0000, 32'hFFFF_FFFF);
      ww(`OFS_CONTROL_FIRST, 32'h0000_0001);
      pulse(12'h001);
      pulse(12'h00C);
      rr(`OFS_STATUS_FIRST);
      chk_reg(32'h0000_000B, 32'h0000_000B);
      ww(`OFS_DATA_HOLD, 32'h0000_0000);
      rr(`OFS_STATUS_FIRST);
      chk_reg(32'h0000_0002, 32'h0000_000B);
      rr(`OFS_STATUS_SECOND);
      rr(`OFS_STATUS_FIRST);
      chk_reg(32'h0000_0000, 32'h0000_0002);
      dsend <= 1'b1;
      pulse(12'h200);
      rr(`OFS_STATUS_SECOND);
      chk_reg(32'h0000_0005, 32'h0000_0005);
      pulse(12'h010);
      chk_pin(1'b0, mst);
      rr(`OFS_STATUS_SECOND);
      chk_reg(32'h0000_0000, 32'h0000_0005);
      rr(`OFS_STATUS_FIRST);
      chk_reg(32'h0000_0200, 32'h0000_0200);
      pm.bus_start();
      repeat (8) @(negedge clk);
      chk_pin(1'b1, bsy);
      pm.clocks(9);
      pm.bus_stop();
      repeat (8) @(negedge clk);
      chk_pin(1'b0, bsy);
      rr(`OFS_STATUS_FIRST);
      chk_reg(32'h0000_0010, 32'h0000_0010);
      ww(`OFS_CONTROL_FIRST, 32'h0000_0001);
      rr(`OFS_STATUS_FIRST);
      chk_reg(32'h0000_0000, 32'h0000_0010);
      for (int i = 0; i < 8; i++) begin
         m = 12'($urandom) & 12'h1E0;
         scnd <= 1'($urandom);
         pulse(m);
         rr(`OFS_STATUS_SECOND);
         chk_reg({24'h0, m[5] & scnd, m[7], m[8], m[6], 4'h0},
                 32'h0000_00F0);
         pulse(i[0] ? 12'h001 : 12'h002);
         rr(`OFS_STATUS_SECOND);
         chk_reg(32'h0000_0000, 32'h0000_00F0);
         if (i[0])
            pulse(12'h002);
      end
      empty <= 1'b1;
      pulse(12'h9E1);
      chk_pin(1'b1, hold);
      ww(`OFS_CONTROL_FIRST, 32'h0000_0000);
      rr(`OFS_STATUS_SECOND);
      chk_reg(32'h0000_0000, 32'h0000_00F5);
      chk_pin(1'b0, hold);
      ww(`OFS_CONTROL_FIRST, 32'h0000_0081);
      pulse(12'h800);
      chk_pin(1'b0, hold);
      ww(`OFS_CONTROL_FIRST, 32'h0000_0001);
      pulse(12'h800);
      chk_pin(1'b1, hold);
      rr(`OFS_STATUS_FIRST);
      ww(`OFS_DATA_HOLD, 32'h0000_0000);
      rr(`OFS_STATUS_FIRST);
      chk_reg(32'h0000_0000, 32'h0000_0004);
      empty <= 1'b0;
      rr(8'h40);
      b1 = 8'($urandom);
      b2 = 8'($urandom);
      pulse(12'h400, b1);
      pulse(12'h400, b2);
      chk_pin(1'b1, hold);
      rr(`OFS_DATA_HOLD);
      chk_reg({24'h0, b1}, 32'h0000_00FF);
      rr(`OFS_STATUS_FIRST);
      chk_reg(32'h0000_0044, 32'h0000_0044);
      pulse(12'h002);
      chk_pin(1'b0, hold);
      rr(`OFS_DATA_HOLD);
      chk_reg({24'h0, b2}, 32'h0000_00FF);
      rr(`OFS_STATUS_FIRST);
      chk_reg(32'h0000_0000, 32'h0000_0040);
      ww(`OFS_CONTROL_FIRST, 32'h0000_0003);
      pec <= 8'($urandom);
      rr(`OFS_STATUS_SECOND);
      chk_reg({16'h0000, pec, 8'h00}, 32'h0000_FF00);
      print_verdict();
   end
endmodule : tb_top
bind i2c_transfer_status_flags i2c_flag_checker chk (
   .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .address_i(address_i),
   .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
   .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
   .scl_i(scl_i), .sda_i(sda_i), .start_gen_i(start_gen_i),
   .stop_gen_i(stop_gen_i), .arb_lost_i(arb_lost_i),
   .rx_byte_done_i(rx_byte_done_i), .tx_byte_done_i(tx_byte_done_i),
   .pec_value_i(pec_value_i), .peripheral_on_o(peripheral_on_o),
   .pec_enable_o(pec_enable_o), .scl_hold_o(scl_hold_o),
   .master_mode_o(master_mode_o), .bus_active_o(bus_active_o));
